//--- wave_map.svh
// Register offsets, field positions and reset values of the waveform source
`ifndef WAVE_MAP_SVH
`define WAVE_MAP_SVH

`define OFS_POWER_CONFIG 15'h0001
`define OFS_CLOCK_CONFIG 15'h0002
`define OFS_PATTERN_STATUS 15'h001E
`define OFS_SYNTH_CONFIG 15'h0026
`define OFS_WAVE_SELECT 15'h0027
`define OFS_PATTERN_PERIOD 15'h0029
`define OFS_CONSTANT_LEVEL 15'h0031
`define OFS_RAMP_CONFIG 15'h0037
`define OFS_TUNING_UPPER 15'h003E
`define OFS_TUNING_LOWER 15'h003F
`define OFS_CYCLE_COUNT 15'h0042
`define OFS_PHASE_OFFSET 15'h0043
`define OFS_START_DELAY 15'h005C
`define OFS_START_ADDR 15'h005D
`define OFS_STOP_ADDR 15'h005E
`define RAM_BASE_TOP 3'h6

`define BIT_DAC_SLEEP 3
`define BIT_CLOCK_GATE_OFF 5
`define BIT_RUN 0
`define BIT_PATTERN 1
`define BIT_MEM_ACCESS 2
`define BIT_BUF_READ 3
`define BIT_MSB_CLOCKS 2
`define BIT_TW_FROM_RAM 0

`define SRC_RAMP 2'h1
`define SRC_NOISE 2'h2
`define MIDSCALE 14'h2000
`define LFSR_SEED 16'hACE1
`define REG_RESET 16'h0000

`endif

//--- wave_pkg.sv
// Types shared by the waveform source blocks
package wave_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_delay = 3'b010,
    st_play = 3'b100
  } pat_state_e;
  typedef enum logic [1:0] {
    wk_ram = 2'h0,
    wk_prestored = 2'h1,
    wk_sine = 2'h2,
    wk_am = 2'h3
  } wave_kind_e;
endpackage

//--- wave_fifo.sv
// Sample FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module wave_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("FIFO depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = store[rd_ptr[AW-1:0]];

  // Pointer update
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge clock) begin
    if (push) store[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

//--- waveform_source_and_sram.sv
// Waveform source: SPI registers, pattern SRAM, synthesizer and pattern sequencer
// Functional notes
// - Synthesizer uses a 24-bit tuning word
// - Tuning word from registers or SRAM list
// - Pattern memory holds 4096 fourteen-bit words
// - Memory mapped at SPI addresses 0x6000-0x6FFF
// - While running, access only outside start-stop window
// - Running reads memory start-to-stop after delay
// - Address counter steps on clock or MSB
// - Each listed frequency lasts one sample, or with MSB stepping one sine cycle (the first only half a cycle)
// - Ramp selection routes ramp into datapath
// - Ramp shape selectable, step held programmed samples
// - Noise output is continuous only
// - Constant level output is continuous only
// - Sleep bit puts converter asleep
// - Clock gate bit stops generator and datapath
// - Pulsed sine: delay, then counted whole cycles
// - Envelope mode multiplies sine by memory samples
// - Clearing run stops counter and memory output
// - Phase offset added to synthesizer output
`timescale 1ns/1ns
`default_nettype none
`include "wave_map.svh"
module waveform_source_and_sram import wave_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic [13:0] dac_data,
  output logic dac_valid,
  input wire logic dac_ready,
  output logic dac_sleep,
  output logic pattern_on
);
  // Configuration registers
  logic sleep_bit, clock_gate_off, run, mem_access, buf_read;
  logic msb_clocks_counter, tw_from_ram;
  logic [1:0] wave_kind, source_select, ramp_shape;
  logic [5:0] ramp_step_length;
  logic [13:0] constant_level_reg;
  logic [15:0] tuning_word_upper, tuning_word_lower, sine_cycle_count, sine_phase_offset;
  logic [15:0] pattern_period, start_delay;
  logic [11:0] start_addr, stop_addr;

  // SPI slave: inputs pass two flip-flops, a third stage finds clock edges
  logic [2:0] sclk_s;
  logic [1:0] cs_s, sdi_s;
  logic [5:0] bit_cnt;
  logic [15:0] shift_in, out_shift, cmd, rd_data;
  logic [15:0] next_shift;
  logic sclk_rise, sclk_fall, cs_act;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_s <= 3'h0;
      cs_s <= 2'h3;
      sdi_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_sclk};
      cs_s <= {cs_s[0], spi_cs_n};
      sdi_s <= {sdi_s[0], spi_sdi};
    end
  end

  assign sclk_rise = sclk_s[1] && !sclk_s[2];
  assign sclk_fall = !sclk_s[1] && sclk_s[2];
  assign cs_act = !cs_s[1];
  assign next_shift = {shift_in[14:0], sdi_s[1]};

  // Frame: 16-bit command (bit 15 high reads), then 16 data bits
  logic spi_wr, spi_rd_load;
  assign spi_wr = cs_act && sclk_rise && bit_cnt == 6'd31 && !cmd[15];
  assign spi_rd_load = cs_act && sclk_rise && bit_cnt == 6'd15;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt <= 6'h0;
      shift_in <= 16'h0;
      cmd <= 16'h0;
      out_shift <= 16'h0;
    end else if (!cs_act) begin
      bit_cnt <= 6'h0;
    end else begin
      if (sclk_rise) begin
        shift_in <= next_shift;
        bit_cnt <= bit_cnt + 6'd1;
        if (bit_cnt == 6'd15) cmd <= next_shift;
      end
      if (spi_rd_load) out_shift <= next_shift[15] ? rd_data : 16'h0;
      else if (sclk_fall && bit_cnt >= 6'd17) out_shift <= {out_shift[14:0], 1'b0};
    end
  end
  assign spi_sdo = out_shift[15];

  // Pattern memory and its SPI access policy
  logic [13:0] mem [4096];
  logic [11:0] addr_cnt;
  logic [13:0] ram_q;
  logic [14:0] rd_addr;
  logic rd_is_ram, wr_is_ram, rd_ok, wr_ok;
  pat_state_e state;

  function automatic logic ram_allowed(input logic [14:0] a, input logic rd);
    logic in_window;
    in_window = a[11:0] >= start_addr && a[11:0] <= stop_addr;
    if (run) ram_allowed = !in_window;
    else ram_allowed = mem_access && (buf_read == rd);
  endfunction

  assign rd_addr = next_shift[14:0];
  assign rd_is_ram = rd_addr[14:12] == `RAM_BASE_TOP;
  assign wr_is_ram = cmd[14:12] == `RAM_BASE_TOP;
  // Access policy; a process so that mode and window changes re-evaluate it
  always_comb begin
    rd_ok = ram_allowed(rd_addr, 1'b1);
    wr_ok = ram_allowed(cmd[14:0], 1'b0);
  end
  assign ram_q = mem[addr_cnt];

  always_ff @(posedge clock) begin
    if (spi_wr && wr_is_ram && wr_ok) mem[cmd[11:0]] <= next_shift[13:0];
  end

  // Register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sleep_bit <= 1'b0;
      clock_gate_off <= 1'b0;
      run <= 1'b0;
      mem_access <= 1'b0;
      buf_read <= 1'b0;
      msb_clocks_counter <= 1'b0;
      tw_from_ram <= 1'b0;
      wave_kind <= 2'h0;
      source_select <= 2'h0;
      ramp_shape <= 2'h0;
      ramp_step_length <= 6'h0;
      constant_level_reg <= 14'h0;
      tuning_word_upper <= `REG_RESET;
      tuning_word_lower <= `REG_RESET;
      sine_cycle_count <= `REG_RESET;
      sine_phase_offset <= `REG_RESET;
      pattern_period <= `REG_RESET;
      start_delay <= `REG_RESET;
      start_addr <= 12'h0;
      stop_addr <= 12'h0;
    end else if (spi_wr) begin
      if (cmd[14:0] == `OFS_POWER_CONFIG) sleep_bit <= next_shift[`BIT_DAC_SLEEP];
      else if (cmd[14:0] == `OFS_CLOCK_CONFIG) clock_gate_off <= next_shift[`BIT_CLOCK_GATE_OFF];
      else if (cmd[14:0] == `OFS_PATTERN_STATUS) begin
        run <= next_shift[`BIT_RUN];
        mem_access <= next_shift[`BIT_MEM_ACCESS];
        buf_read <= next_shift[`BIT_BUF_READ];
      end else if (cmd[14:0] == `OFS_SYNTH_CONFIG) begin
        msb_clocks_counter <= next_shift[`BIT_MSB_CLOCKS];
        tw_from_ram <= next_shift[`BIT_TW_FROM_RAM];
      end else if (cmd[14:0] == `OFS_WAVE_SELECT) begin
        wave_kind <= next_shift[1:0];
        source_select <= next_shift[5:4];
      end else if (cmd[14:0] == `OFS_RAMP_CONFIG) begin
        ramp_shape <= next_shift[1:0];
        ramp_step_length <= next_shift[7:2];
      end else if (cmd[14:0] == `OFS_CONSTANT_LEVEL) constant_level_reg <= next_shift[13:0];
      else if (cmd[14:0] == `OFS_TUNING_UPPER) tuning_word_upper <= next_shift;
      else if (cmd[14:0] == `OFS_TUNING_LOWER) tuning_word_lower <= next_shift;
      else if (cmd[14:0] == `OFS_CYCLE_COUNT) sine_cycle_count <= next_shift;
      else if (cmd[14:0] == `OFS_PHASE_OFFSET) sine_phase_offset <= next_shift;
      else if (cmd[14:0] == `OFS_PATTERN_PERIOD) pattern_period <= next_shift;
      else if (cmd[14:0] == `OFS_START_DELAY) start_delay <= next_shift;
      else if (cmd[14:0] == `OFS_START_ADDR) start_addr <= next_shift[11:0];
      else if (cmd[14:0] == `OFS_STOP_ADDR) stop_addr <= next_shift[11:0];
    end
  end

  // Read data for the addressed register or memory word; unmapped reads zero
  always_comb begin
    rd_data = 16'h0;
    if (rd_is_ram) rd_data = rd_ok ? {2'h0, mem[rd_addr[11:0]]} : 16'h0;
    else if (rd_addr == `OFS_POWER_CONFIG) rd_data[`BIT_DAC_SLEEP] = sleep_bit;
    else if (rd_addr == `OFS_CLOCK_CONFIG) rd_data[`BIT_CLOCK_GATE_OFF] = clock_gate_off;
    else if (rd_addr == `OFS_PATTERN_STATUS) rd_data = {12'h0, buf_read, mem_access, state != st_idle, run};
    else if (rd_addr == `OFS_SYNTH_CONFIG) rd_data = {13'h0, msb_clocks_counter, 1'b0, tw_from_ram};
    else if (rd_addr == `OFS_WAVE_SELECT) rd_data = {10'h0, source_select, 2'h0, wave_kind};
    else if (rd_addr == `OFS_RAMP_CONFIG) rd_data = {8'h0, ramp_step_length, ramp_shape};
    else if (rd_addr == `OFS_CONSTANT_LEVEL) rd_data = {2'h0, constant_level_reg};
    else if (rd_addr == `OFS_TUNING_UPPER) rd_data = tuning_word_upper;
    else if (rd_addr == `OFS_TUNING_LOWER) rd_data = tuning_word_lower;
    else if (rd_addr == `OFS_CYCLE_COUNT) rd_data = sine_cycle_count;
    else if (rd_addr == `OFS_PHASE_OFFSET) rd_data = sine_phase_offset;
    else if (rd_addr == `OFS_PATTERN_PERIOD) rd_data = pattern_period;
    else if (rd_addr == `OFS_START_DELAY) rd_data = start_delay;
    else if (rd_addr == `OFS_START_ADDR) rd_data = {4'h0, start_addr};
    else if (rd_addr == `OFS_STOP_ADDR) rd_data = {4'h0, stop_addr};
  end

  // Generator advances only when the FIFO takes a sample and clocks are on
  logic fifo_ready, step, enter_play;
  assign step = fifo_ready && !clock_gate_off;

  // Synthesizer: tuning word, accumulator, phase offset, parabolic sine
  logic [23:0] tw, acc, phase_sum;
  logic msb_prev, msb_rise, msb_fall;
  logic [12:0] sin_x;
  logic [25:0] sin_prod;
  logic [13:0] sine_s;
  logic [28:0] am_prod;

  assign tw = tw_from_ram ? {tuning_word_upper[15:6], ram_q}
                          : {tuning_word_upper, tuning_word_lower[15:8]};
  assign phase_sum = acc + {sine_phase_offset, 8'h00};
  assign msb_rise = step && acc[23] && !msb_prev;
  assign msb_fall = step && !acc[23] && msb_prev;
  assign sin_x = phase_sum[22:10];
  assign sin_prod = {13'h0, sin_x} * {13'h0, ~sin_x};
  assign sine_s = phase_sum[23] ? 14'(-{1'b0, sin_prod[24:12]}) : {1'b0, sin_prod[24:12]};
  assign am_prod = $signed({{15{sine_s[13]}}, sine_s}) * $signed({15'h0, ram_q});

  // Phase restarts at play entry so whole cycles are counted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc <= 24'h0;
      msb_prev <= 1'b0;
    end else if (step) begin
      acc <= enter_play ? 24'h0 : acc + tw;
      msb_prev <= enter_play ? 1'b0 : acc[23];
    end
  end

  // Pattern sequencer: period, start delay, play
  logic [15:0] period_cnt, delay_cnt, cyc_cnt;
  logic addr_done, adv, period_end;
  assign enter_play = step && state == st_delay && delay_cnt >= start_delay;
  assign adv = msb_clocks_counter ? msb_rise : step;
  assign period_end = pattern_period != 16'h0 && period_cnt == pattern_period - 16'd1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      period_cnt <= 16'h0;
      delay_cnt <= 16'h0;
    end else if (!run) begin
      state <= st_idle;
    end else if (step) begin
      case (state)
        st_idle: begin
          state <= st_delay;
          period_cnt <= 16'h0;
          delay_cnt <= 16'h0;
        end
        default: begin
          period_cnt <= period_end ? 16'h0 : period_cnt + 16'd1;
          if (period_end) begin
            state <= st_delay;
            delay_cnt <= 16'h0;
          end else if (enter_play) state <= st_play;
          else if (state == st_delay) delay_cnt <= delay_cnt + 16'd1;
        end
      endcase
    end
  end

  // Address counter and sine cycle counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_cnt <= 12'h0;
      addr_done <= 1'b0;
      cyc_cnt <= 16'h0;
    end else if (enter_play) begin
      addr_cnt <= start_addr;
      addr_done <= 1'b0;
      cyc_cnt <= 16'h0;
    end else if (state == st_play && run) begin
      if (adv && !addr_done) begin
        if (addr_cnt == stop_addr) addr_done <= 1'b1;
        else addr_cnt <= addr_cnt + 12'd1;
      end
      if (msb_fall && cyc_cnt != sine_cycle_count) cyc_cnt <= cyc_cnt + 16'd1;
    end
  end

  // Ramp generator and noise source
  logic [13:0] ramp_val;
  logic [5:0] ramp_hold;
  logic ramp_down;
  logic [15:0] lfsr;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ramp_val <= 14'h0;
      ramp_hold <= 6'h0;
      ramp_down <= 1'b0;
    end else if (step) begin
      if (ramp_hold + 6'd1 >= ramp_step_length) begin
        ramp_hold <= 6'h0;
        if (ramp_shape == 2'h1) ramp_val <= ramp_val - 14'd1;
        else if (ramp_shape == 2'h2) begin
          ramp_val <= ramp_down ? ramp_val - 14'd1 : ramp_val + 14'd1;
          if (ramp_val == (ramp_down ? 14'h0001 : 14'h3FFE)) ramp_down <= !ramp_down;
        end else ramp_val <= ramp_val + 14'd1;
      end else ramp_hold <= ramp_hold + 6'd1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) lfsr <= `LFSR_SEED;
    else if (step) lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  // Waveform selector, offset-binary samples, midscale when quiet
  logic [13:0] sample;
  logic ram_live, sine_live;
  assign ram_live = state == st_play && !addr_done;
  assign sine_live = state == st_play && cyc_cnt < sine_cycle_count;
  always_comb begin
    sample = `MIDSCALE;
    case (wave_kind)
      wk_ram: if (ram_live) sample = ram_q;
      wk_prestored: begin
        if (source_select == `SRC_RAMP) begin
          if (state == st_play && ramp_shape != 2'h3) sample = ramp_val;
        end else if (state != st_idle) begin
          sample = source_select == `SRC_NOISE ? lfsr[13:0] : constant_level_reg;
        end
      end
      wk_sine: if (sine_live) sample = sine_s ^ `MIDSCALE;
      default: if (ram_live) sample = am_prod[27:14] ^ `MIDSCALE;
    endcase
  end

  wave_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(!clock_gate_off),
    .in_ready(fifo_ready),
    .in_data(sample),
    .out_valid(dac_valid),
    .out_ready(dac_ready),
    .out_data(dac_data)
  );

  assign dac_sleep = sleep_bit;
  assign pattern_on = state != st_idle;

  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  run_clear_idle_a: assert property (!run |=> state == st_idle)
    else $error("pattern kept running after run cleared");
  phase_accum_a: assert property (step && !enter_play |=> acc == 24'($past(acc) + $past(tw)))
    else $error("phase accumulator did not add tuning word");
  gate_hold_a: assert property (clock_gate_off |=> $stable(acc) && $stable(lfsr))
    else $error("generator moved while clock gated");
  play_range_a: assert property (state == st_play && start_addr <= stop_addr && !enter_play
    |-> addr_cnt >= start_addr && addr_cnt <= stop_addr)
    else $error("address counter left start-stop window");
  delay_done_a: assert property ($rose(state == st_play) |-> $past(delay_cnt) >= $past(start_delay))
    else $error("play began before start delay elapsed");
  msb_step_a: assert property (msb_clocks_counter && state == st_play && !msb_rise && !enter_play
    |=> $stable(addr_cnt))
    else $error("address moved without synthesizer MSB edge");
  noise_cont_a: assert property (run && wave_kind == wk_prestored && source_select == `SRC_NOISE
    && state != st_idle |-> sample == lfsr[13:0])
    else $error("noise not continuous");
  const_level_a: assert property (wave_kind == wk_prestored && source_select == 2'h0 && state == st_delay
    |-> sample == constant_level_reg)
    else $error("constant level not output");
  sine_count_a: assert property (wave_kind == wk_sine && state == st_play && cyc_cnt == sine_cycle_count
    |-> sample == `MIDSCALE)
    else $error("sine passed beyond cycle count");
  ram_guard_a: assert property (spi_wr && wr_is_ram && run && cmd[11:0] >= start_addr && cmd[11:0] <= stop_addr
    |=> $stable(mem[$past(cmd[11:0])]))
    else $error("memory written inside active window");
endmodule
`default_nettype wire

//--- spi_host_model.sv
// SPI host model that frames register and memory accesses
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input wire logic clock,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // Each half of the serial clock lasts five system clocks, above the three the design needs
  localparam int HALF = 5;

  // Idle bus: deselected, serial clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // Wait some clock edges, then move just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // One frame: command word then data word, MSB first, sampled on the serial clock rise
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic [31:0] word;
    word = {rd, addr, wdata};
    rdata = 16'h0000;
    tick(1);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdi = word[i];
      tick(HALF);
      if (i < 16) rdata[i] = sdo; // Read bits settle before each rise from the 17th on
      sclk = 1'b1;
      tick(HALF);
      sclk = 1'b0;
    end
    tick(HALF);
    cs_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale data
    tick(10); // Deselect gap lets chip select pass its synchronizer and clear the bit count before the next frame
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the waveform source
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {logic rd; logic [14:0] addr; logic [15:0] val;} row_s;
  logic clock, rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, dac_valid, dac_ready, dac_sleep, pattern_on;
  logic [13:0] dac_data, held;
  logic [15:0] got;
  int errors, comparisons, cycles, ups, diffs;
  // Register and memory accesses: write rows, or read rows with the expected data
  row_s rows [0:22] = '{
    {1'b0, 15'h001E, 16'h0004}, {1'b0, 15'h6005, 16'h3ABC}, // write mode
    {1'b0, 15'h6FFF, 16'hFFFF}, {1'b0, 15'h6015, 16'h0444}, {1'b1, 15'h6005, 16'h0000},
    {1'b0, 15'h001E, 16'h0008}, {1'b0, 15'h6005, 16'h0111},
    {1'b0, 15'h001E, 16'h000C}, {1'b1, 15'h6005, 16'h3ABC}, // read mode
    {1'b1, 15'h6FFF, 16'h3FFF}, {1'b1, 15'h001E, 16'h000C},
    {1'b0, 15'h001E, 16'h000E}, {1'b1, 15'h001E, 16'h000C},
    {1'b0, 15'h0010, 16'h1234}, {1'b1, 15'h0010, 16'h0000},
    {1'b0, 15'h005D, 16'h0010}, {1'b0, 15'h005E, 16'h0020},
    {1'b0, 15'h001E, 16'h0005}, {1'b0, 15'h6021, 16'h0222},
    {1'b0, 15'h6015, 16'h0999}, {1'b1, 15'h6021, 16'h0222},
    {1'b1, 15'h6015, 16'h0000}, {1'b0, 15'h001E, 16'h0000}
  };

  waveform_source_and_sram #(.FIFO_DEPTH(16)) u_dut (
    .clock(clock), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .dac_data(dac_data), .dac_valid(dac_valid), .dac_ready(dac_ready),
    .dac_sleep(dac_sleep), .pattern_on(pattern_on)
  );
  spi_host_model u_host (.clock(clock), .sclk(spi_sclk), .cs_n(spi_cs_n), .sdi(spi_sdi), .sdo(spi_sdo));

  // 50 MHz clock
  always #10 clock = ~clock;

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [14:0] addr, input logic [15:0] data);
    u_host.xfer(1'b0, addr, data, got);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // Ten taken samples: count rises and changes between neighbours
  task automatic collect();
    logic [13:0] prev;
    ups = 0;
    diffs = 0;
    prev = dac_data;
    repeat (10) begin
      settle(1);
      if (dac_data > prev) ups++;
      if (dac_data !== prev) diffs++;
      prev = dac_data;
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    dac_ready = 1'b1;
    settle(19);
    check("reset valid", {15'h0, dac_valid}, 16'h0000);
    check("reset sleep", {15'h0, dac_sleep}, 16'h0000);
    check("reset pattern", {15'h0, pattern_on}, 16'h0000);
    check("reset sdo", {15'h0, spi_sdo}, 16'h0000);
    settle(1);
    rst = 1'b0;
    settle(3);
    foreach (rows[i]) begin
      u_host.xfer(rows[i].rd, rows[i].addr, rows[i].rd ? 16'h0000 : rows[i].val, got);
      if (rows[i].rd) check("spi read", got, rows[i].val);
    end
    // Constant level while running
    wr(15'h0031, 16'h0123);
    wr(15'h0027, 16'h0001);
    wr(15'h001E, 16'h0001);
    settle(40);
    check("pattern on", {15'h0, pattern_on}, 16'h0001);
    check("constant", {2'b00, dac_data}, 16'h0123);
    // Far side stalls: FIFO fills and holds its head
    dac_ready = 1'b0;
    settle(40);
    held = dac_data;
    settle(5);
    check("stall valid", {15'h0, dac_valid}, 16'h0001);
    check("stall data", {2'b00, dac_data}, {2'b00, held});
    dac_ready = 1'b1;
    // Clock gate stops the generator, the FIFO then drains
    wr(15'h0002, 16'h0020);
    settle(40);
    check("gated valid", {15'h0, dac_valid}, 16'h0000);
    wr(15'h0002, 16'h0000);
    settle(5);
    check("ungated valid", {15'h0, dac_valid}, 16'h0001);
    // Sleep bit
    wr(15'h0001, 16'h0008);
    check("sleep on", {15'h0, dac_sleep}, 16'h0001);
    wr(15'h0001, 16'h0000);
    check("sleep off", {15'h0, dac_sleep}, 16'h0000);
    // Rising ramp, one sample per step
    wr(15'h0037, 16'h0004);
    wr(15'h0027, 16'h0011);
    settle(40);
    collect();
    check("ramp rises", 16'(ups >= 8), 16'h0001);
    // Noise keeps changing
    wr(15'h0027, 16'h0021);
    settle(40);
    collect();
    check("noise moves", 16'(diffs >= 5), 16'h0001);
    // Clearing run stops the sequencer and the ramp output
    wr(15'h0027, 16'h0011);
    wr(15'h001E, 16'h0000);
    settle(40);
    check("pattern off", {15'h0, pattern_on}, 16'h0000);
    check("idle level", {2'b00, dac_data}, 16'h2000);
    // Pulsed sine: two whole cycles of sixteen samples, then midscale
    wr(15'h003E, 16'h1000);
    wr(15'h0042, 16'h0002);
    wr(15'h0026, 16'h0004);
    wr(15'h0027, 16'h0002);
    wr(15'h001E, 16'h0001);
    collect();
    check("sine moves", 16'(diffs >= 5), 16'h0001);
    settle(40);
    check("sine pattern", {15'h0, pattern_on}, 16'h0001);
    check("sine ends", {2'b00, dac_data}, 16'h2000);
    // Reset in mid-run clears the registers and the sequencer
    wr(15'h0001, 16'h0008);
    rst = 1'b1;
    settle(2);
    rst = 1'b0;
    settle(3);
    check("rerun sleep", {15'h0, dac_sleep}, 16'h0000);
    check("rerun pattern", {15'h0, pattern_on}, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
